// ### bms_regs.svh
// timing counts, field sizes and command codes of the measurement sequencer
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH

`define BMS_CLK_HZ          20000000
`define BMS_TICK_US         1000
`define BMS_CYC_PER_TICK    ((`BMS_CLK_HZ / 1000000) * `BMS_TICK_US)
`define BMS_ROUND_BASE_MS   2000
`define BMS_ROUND_EXT_MS    500
`define BMS_WHATIF_EXT_MS   500
`define BMS_WHATIF_PER_MS   20000
`define BMS_CELL_WIN_MS     250
`define BMS_THERM_WIN_MS    60
`define BMS_NUM_CELLS       4
`define BMS_CAL_CMD         16'h0062
`define BMS_CAL_LOG2        3
`define BMS_OFS_FRAC        3

`endif

// ### bms_pkg.sv
// types shared by the measurement sequencer and its charge counter
package bms_pkg;

    typedef enum logic [2:0]
    {
        CH_TEMP,
        CH_PACK,
        CH_CURR,
        CH_CELL1,
        CH_CELL2,
        CH_CELL3,
        CH_CELL4
    } bms_chan_e;

    typedef enum logic [1:0]
    {
        S_WAIT,
        S_THERM,
        S_MEAS,
        S_CELL
    } bms_state_e;

    typedef struct packed
    {
        logic      start;
        bms_chan_e chan;
    } bms_conv_s;

    typedef struct packed
    {
        logic level;
        logic oe;
    } bms_switch_s;

endpackage : bms_pkg

// ### bms_charge_counter.sv
// signed charge integration with offset calibration and digital filter
`timescale 1ns/1ps
`include "bms_regs.svh"

module bms_charge_counter
    import bms_pkg::*;
#(
    parameter int unsigned W     = 16,
    parameter int unsigned ACC_W = 40
)
(
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    sense_valid_i,
    input  wire logic signed [W-1:0]     sense_input_high_i,
    input  wire logic signed [W-1:0]     sense_input_low_i,
    input  wire logic        [W-1:0]     filter_threshold_i,
    input  wire logic                    cal_start_i,
    output logic signed      [ACC_W-1:0] charge_count_o,
    output logic                         charge_act_o,
    output logic                         discharge_act_o,
    output logic                         cal_busy_o
);
    localparam int unsigned F  = `BMS_OFS_FRAC;
    localparam int unsigned DW = W + 1 + F;

    initial
    begin
        if (ACC_W < DW + 2 || F != `BMS_CAL_LOG2)
            $error("bms_charge_counter: unsupported widths");
    end

    logic signed [W:0]         diff;
    logic signed [DW-1:0]      diff_sc;
    logic signed [DW:0]        corr;
    logic        [DW:0]        mag;
    logic        [DW:0]        thr_sc;
    logic                      pass;
    logic signed [DW-1:0]      offset_q;
    logic signed [DW-1:0]      cal_sum_q;
    logic        [F-1:0]       cal_cnt_q;

    // offset held in eighths of a count, well under one microvolt
    always_comb
    begin
        diff    = (W+1)'(sense_input_high_i) - (W+1)'(sense_input_low_i);
        diff_sc = {{(F){diff[W]}}, diff} <<< F;
        corr    = (DW+1)'(diff_sc) - (DW+1)'(offset_q);
        mag     = corr[DW] ? (DW+1)'(-corr) : (DW+1)'(corr);
        thr_sc  = (DW+1)'({filter_threshold_i, {F{1'b0}}});
        pass    = (mag >= thr_sc) && (mag != '0);
    end

    //------------------------------------------------------------------
    // offset calibration
    //------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cal_busy_o <= 1'b0;
            cal_cnt_q  <= '0;
            cal_sum_q  <= '0;
            offset_q   <= '0;
        end
        else if (!cal_busy_o)
        begin
            if (cal_start_i)
            begin
                cal_busy_o <= 1'b1;
                cal_cnt_q  <= '0;
                cal_sum_q  <= '0;
            end
        end
        else if (sense_valid_i)
        begin
            cal_cnt_q <= cal_cnt_q + 1'b1;
            cal_sum_q <= cal_sum_q + DW'(diff);
            if (&cal_cnt_q)
            begin
                offset_q   <= cal_sum_q + DW'(diff);
                cal_busy_o <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // integration
    //------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            charge_count_o  <= '0;
            charge_act_o    <= 1'b0;
            discharge_act_o <= 1'b0;
        end
        else
        begin
            charge_act_o    <= 1'b0;
            discharge_act_o <= 1'b0;
            // counts are frozen while the offset is being learnt
            if (sense_valid_i && !cal_busy_o && pass)
            begin
                charge_count_o  <= charge_count_o + ACC_W'(corr);
                charge_act_o    <= !corr[DW];
                discharge_act_o <= corr[DW];
            end
        end
    end

    a_filter_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sense_valid_i && !pass) |=> $stable(charge_count_o))
        else $error("count below filter threshold reached the counter");

    a_sign_class: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sense_valid_i && !cal_busy_o && pass && !corr[DW])
        |=> charge_act_o && !discharge_act_o)
        else $error("positive sense difference not classed as charge");

endmodule : bms_charge_counter

// ### bms_sequencer.sv
// measurement round scheduler, result registers and switch outputs
//
// Behaviour
// - a round of pack voltage, current and temperature runs every 2 to 3 s.
// - the 2.5 s interval applies when compensated END_OF_DISCHARGE_VOLTAGE, mWh and max rate all hold.
// - what-if runs every 20 s or on request, stretching that interval by 0.5 s.
// - sense high above sense low counts as charge, below it as discharge.
// - the signed flow is integrated continuously in the charge counter.
// - a calibration command on the vendor command register starts offset cancel.
// - calibration trims the offset to sub-microvolt resolution of the count.
// - counts whose magnitude is under the filter threshold are discarded.
// - the filter threshold comes from configuration memory, set above idle noise.
// - each round measures pack voltage into the pack voltage register.
// - each round measures up to four cells, one register slot per cell.
// - the cell divider switch floats for 250 ms of cell conversion, low otherwise.
// - each round converts the current sense input into the current register.
// - the thermistor bias switch floats for 60 ms of temperature, low otherwise.
`timescale 1ns/1ps
`include "bms_regs.svh"

module bms_sequencer
    import bms_pkg::*;
#(
    parameter int unsigned W          = 16,
    parameter int unsigned ACC_W      = 40,
    parameter int unsigned CYC_PER_MS = `BMS_CYC_PER_TICK,
    parameter int unsigned NUM_CELLS  = `BMS_NUM_CELLS
)
(
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        sense_valid_i,
    input  wire logic signed [W-1:0]         sense_input_high_i,
    input  wire logic signed [W-1:0]         sense_input_low_i,
    input  wire logic        [W-1:0]         filter_threshold_i,
    input  wire logic                        vendor_cmd_wr_i,
    input  wire logic        [15:0]          vendor_command_register_i,
    input  wire logic                        comp_edv_i,
    input  wire logic                        mwh_mode_i,
    input  wire logic                        max_rate_i,
    input  wire logic                        what_if_req_i,
    input  wire logic                        conv_done_i,
    input  wire logic        [W-1:0]         conv_result_i,
    output bms_conv_s                        conv_o,
    output logic                             what_if_start_o,
    output logic                             round_done_o,
    output bms_switch_s                      cell_divider_switch_o,
    output bms_switch_s                      thermistor_bias_switch_o,
    output logic             [W-1:0]         temperature_o,
    output logic             [W-1:0]         pack_voltage_o,
    output logic             [W-1:0]         current_o,
    output logic [NUM_CELLS-1:0][W-1:0]      cell_voltage_inputs_o,
    output logic signed      [ACC_W-1:0]     charge_count_o,
    output logic                             charge_act_o,
    output logic                             discharge_act_o,
    output logic                             cal_busy_o
);
    initial
    begin
        if (NUM_CELLS < 1 || NUM_CELLS > 4 || CYC_PER_MS < 2)
            $error("bms_sequencer: unsupported parameters");
    end

    //------------------------------------------------------------------
    // time base
    //------------------------------------------------------------------
    logic [$clog2(CYC_PER_MS)-1:0] pre_q;
    logic                          tick_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (pre_q == $bits(pre_q)'(CYC_PER_MS - 1));
            if (pre_q == $bits(pre_q)'(CYC_PER_MS - 1))
                pre_q <= '0;
            else
                pre_q <= pre_q + 1'b1;
        end
    end

    //------------------------------------------------------------------
    // round interval and what-if schedule
    //------------------------------------------------------------------
    localparam logic [15:0] BASE_MS = 16'(`BMS_ROUND_BASE_MS);
    localparam logic [15:0] EXT_MS  = 16'(`BMS_ROUND_EXT_MS);
    localparam logic [15:0] WIF_MS  = 16'(`BMS_WHATIF_EXT_MS);
    localparam logic [15:0] WPER_MS = 16'(`BMS_WHATIF_PER_MS);

    logic [15:0] round_ms_q;
    logic [15:0] interval_q;
    logic [15:0] wif_ms_q;
    logic        round_due_q;
    logic        wif_pend_q;
    logic        round_start;
    bms_state_e  state_q;
    bms_state_e  state_d;

    assign round_start = (state_q == S_WAIT) && round_due_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            round_ms_q  <= '0;
            round_due_q <= 1'b0;
        end
        else
        begin
            if (tick_q && round_ms_q >= interval_q - 16'h0001)
            begin
                round_ms_q  <= '0;
                round_due_q <= 1'b1;
            end
            else
            begin
                if (tick_q)
                    round_ms_q <= round_ms_q + 16'h0001;
                if (round_start)
                    round_due_q <= 1'b0;
            end
        end
    end

    // what-if requests pending across a round are merged, not lost
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wif_ms_q        <= '0;
            wif_pend_q      <= 1'b0;
            interval_q      <= BASE_MS;
            what_if_start_o <= 1'b0;
        end
        else
        begin
            what_if_start_o <= round_start && wif_pend_q;
            if (tick_q)
                wif_ms_q <= (wif_ms_q == WPER_MS - 16'h0001) ? '0
                          : wif_ms_q + 16'h0001;
            if (what_if_req_i || (tick_q && wif_ms_q == WPER_MS - 16'h0001))
                wif_pend_q <= 1'b1;
            else if (round_start)
                wif_pend_q <= 1'b0;
            if (round_start)
                interval_q <= BASE_MS
                    + ((comp_edv_i && mwh_mode_i && max_rate_i)
                       ? EXT_MS : 16'h0000)
                    + (wif_pend_q ? WIF_MS : 16'h0000);
        end
    end

    //------------------------------------------------------------------
    // conversion sequence
    //------------------------------------------------------------------
    localparam logic [15:0] THERM_MS = 16'(`BMS_THERM_WIN_MS);
    localparam logic [15:0] CELL_MS  = 16'(`BMS_CELL_WIN_MS);

    logic [15:0] phase_ms_q;
    logic        busy_q;
    logic [2:0]  step_q;
    logic        seq_done;
    logic        win_over;

    function automatic bms_chan_e chan_of(bms_state_e s, logic [2:0] k);
        bms_chan_e c;
        unique case (s)
            S_THERM: c = CH_TEMP;
            S_MEAS:  c = k[0] ? CH_CURR : CH_PACK;
            S_CELL:  c = bms_chan_e'(3'(CH_CELL1) + k);
            S_WAIT:  c = CH_TEMP;
        endcase
        return c;
    endfunction : chan_of

    function automatic logic [2:0] steps_of(bms_state_e s);
        logic [2:0] n;
        unique case (s)
            S_MEAS:  n = 3'h2;
            S_CELL:  n = 3'(NUM_CELLS);
            S_THERM: n = 3'h1;
            S_WAIT:  n = 3'h0;
        endcase
        return n;
    endfunction : steps_of

    assign seq_done = (step_q == steps_of(state_q)) && !busy_q;
    // entry falls between ticks, so wait for a full count of ticks after it
    assign win_over = tick_q && phase_ms_q >=
                      ((state_q == S_CELL) ? CELL_MS : THERM_MS);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            S_WAIT:  if (round_start) state_d = S_THERM;
            S_THERM: if (seq_done && win_over) state_d = S_MEAS;
            S_MEAS:  if (seq_done) state_d = S_CELL;
            S_CELL:  if (seq_done && win_over) state_d = S_WAIT;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q      <= S_WAIT;
            phase_ms_q   <= '0;
            round_done_o <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            round_done_o <= (state_q == S_CELL) && (state_d == S_WAIT);
            if (state_d != state_q)
                phase_ms_q <= '0;
            else if (tick_q && phase_ms_q != 16'hffff)
                phase_ms_q <= phase_ms_q + 16'h0001;
        end
    end

    // one conversion in flight; a done with nothing pending is ignored
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            conv_o <= '{start: 1'b0, chan: CH_TEMP};
            busy_q <= 1'b0;
            step_q <= '0;
        end
        else
        begin
            conv_o.start <= 1'b0;
            if (state_d != state_q)
                step_q <= '0;
            else if (busy_q && conv_done_i)
            begin
                busy_q <= 1'b0;
                step_q <= step_q + 3'h1;
            end
            else if (!busy_q && step_q < steps_of(state_q))
            begin
                busy_q       <= 1'b1;
                conv_o.start <= 1'b1;
                conv_o.chan  <= chan_of(state_q, step_q);
            end
        end
    end

    //------------------------------------------------------------------
    // result registers, each written whole on its own done
    //------------------------------------------------------------------
    logic take;
    assign take = busy_q && conv_done_i && (state_d == state_q);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            temperature_o  <= '0;
            pack_voltage_o <= '0;
            current_o      <= '0;
        end
        else if (take)
        begin
            if (conv_o.chan == CH_TEMP)
                temperature_o <= conv_result_i;
            if (conv_o.chan == CH_PACK)
                pack_voltage_o <= conv_result_i;
            if (conv_o.chan == CH_CURR)
                current_o <= conv_result_i;
        end
    end

    for (genvar g = 0; g < NUM_CELLS; g++)
    begin : g_cell
        always_ff @(posedge clk_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
                cell_voltage_inputs_o[g] <= '0;
            else if (take && conv_o.chan == bms_chan_e'(3'(CH_CELL1) + 3'(g)))
                cell_voltage_inputs_o[g] <= conv_result_i;
        end
    end

    //------------------------------------------------------------------
    // switch outputs: level always low, float by dropping the enable
    //------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cell_divider_switch_o    <= '{level: 1'b0, oe: 1'b1};
            thermistor_bias_switch_o <= '{level: 1'b0, oe: 1'b1};
        end
        else
        begin
            cell_divider_switch_o.oe    <= (state_d != S_CELL);
            thermistor_bias_switch_o.oe <= (state_d != S_THERM);
        end
    end

    //------------------------------------------------------------------
    // charge counting
    //------------------------------------------------------------------
    logic cal_start;
    assign cal_start = vendor_cmd_wr_i
                    && vendor_command_register_i == `BMS_CAL_CMD;

    bms_charge_counter #(
        .W     (W),
        .ACC_W (ACC_W)
    ) u_charge (
        .clk_i              (clk_i),
        .reset_n_i          (reset_n_i),
        .sense_valid_i      (sense_valid_i),
        .sense_input_high_i (sense_input_high_i),
        .sense_input_low_i  (sense_input_low_i),
        .filter_threshold_i (filter_threshold_i),
        .cal_start_i        (cal_start),
        .charge_count_o     (charge_count_o),
        .charge_act_o       (charge_act_o),
        .discharge_act_o    (discharge_act_o),
        .cal_busy_o         (cal_busy_o)
    );

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    a_cell_float_win: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q == S_CELL && state_d == S_WAIT) |-> phase_ms_q >= CELL_MS)
        else $error("cell switch window shorter than 250 ms");

    a_cell_low_else: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q != S_CELL) |-> cell_divider_switch_o.oe)
        else $error("cell switch released outside cell phase");

    a_therm_float_win: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q == S_THERM && state_d == S_MEAS) |-> phase_ms_q >= THERM_MS)
        else $error("thermistor window shorter than 60 ms");

    a_interval_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $changed(interval_q) |-> interval_q >= BASE_MS
            && interval_q <= BASE_MS + EXT_MS + WIF_MS)
        else $error("round interval out of range");

    a_long_interval: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (round_start && comp_edv_i && mwh_mode_i && max_rate_i && !wif_pend_q)
        |=> interval_q == BASE_MS + EXT_MS)
        else $error("long mode did not stretch the interval");

    a_whatif_ext: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        what_if_start_o |-> interval_q >= BASE_MS + WIF_MS)
        else $error("what-if run did not extend the interval");

    a_pack_update: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (take && conv_o.chan == CH_PACK) |=> pack_voltage_o == $past(conv_result_i))
        else $error("pack voltage not stored from its conversion");

    a_curr_update: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (take && conv_o.chan == CH_CURR) |=> current_o == $past(conv_result_i))
        else $error("current not stored from its conversion");

endmodule : bms_sequencer

// ### bms_conv_model.sv
// converter model answering the sequencer's conversion requests
`timescale 1ns/1ps
module bms_conv_model
    import bms_pkg::*;
(
    input  wire bms_conv_s   conv_i,
    input  wire logic        clk_i,
    input  wire logic [15:0] lat_i,
    output logic             done_o,
    output logic [15:0]      result_o
);
    // result depends on channel so a swapped register shows up
    initial
    begin
        done_o   = 1'b0;
        result_o = 16'h5a5a;
        forever
        begin
            @(negedge clk_i);
            if (conv_i.start === 1'b1)
            begin
                repeat (lat_i) @(negedge clk_i);
                done_o   = 1'b1;
                result_o = 16'h0a00 + 16'(conv_i.chan) * 16'h0111;
                @(negedge clk_i);
                done_o   = 1'b0;
                // stale data is not left on the bus
                result_o = ~result_o;
            end
        end
    end
endmodule : bms_conv_model

// ### tb.sv
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
module tb
    import bms_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int CPM = 4;
    logic clk_i, reset_n_i, sense_valid_i, vendor_cmd_wr_i, conv_done_i;
    logic comp_edv_i, mwh_mode_i, max_rate_i, what_if_req_i;
    logic signed [15:0] sense_input_high_i, sense_input_low_i;
    logic [15:0] filter_threshold_i, vendor_command_register_i;
    logic [15:0] conv_result_i, temperature_o, pack_voltage_o, current_o;
    logic [15:0] lat;
    logic [3:0][15:0] cell_voltage_inputs_o;
    logic signed [39:0] charge_count_o, exp_cc;
    logic what_if_start_o, round_done_o, charge_act_o, discharge_act_o;
    logic cal_busy_o;
    bms_conv_s conv_o;
    bms_switch_s cell_divider_switch_o, thermistor_bias_switch_o;
    int err_total, n_compared, cyc, n_chg, n_dis, n_wif, th_low, cl_low;
    int bad_lvl, s0, s1, s2, s3, s4;

    bms_sequencer #(.CYC_PER_MS(CPM)) uut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .sense_valid_i(sense_valid_i),
        .sense_input_high_i(sense_input_high_i),
        .sense_input_low_i(sense_input_low_i),
        .filter_threshold_i(filter_threshold_i),
        .vendor_cmd_wr_i(vendor_cmd_wr_i),
        .vendor_command_register_i(vendor_command_register_i),
        .comp_edv_i(comp_edv_i), .mwh_mode_i(mwh_mode_i),
        .max_rate_i(max_rate_i), .what_if_req_i(what_if_req_i),
        .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
        .conv_o(conv_o), .what_if_start_o(what_if_start_o),
        .round_done_o(round_done_o),
        .cell_divider_switch_o(cell_divider_switch_o),
        .thermistor_bias_switch_o(thermistor_bias_switch_o),
        .temperature_o(temperature_o), .pack_voltage_o(pack_voltage_o),
        .current_o(current_o), .cell_voltage_inputs_o(cell_voltage_inputs_o),
        .charge_count_o(charge_count_o), .charge_act_o(charge_act_o),
        .discharge_act_o(discharge_act_o), .cal_busy_o(cal_busy_o));
    bms_conv_model far (.conv_i(conv_o), .clk_i(clk_i), .lat_i(lat),
        .done_o(conv_done_i), .result_o(conv_result_i));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cyc++;
        n_chg += (charge_act_o === 1'b1);
        n_dis += (discharge_act_o === 1'b1);
        n_wif += (what_if_start_o === 1'b1);
        th_low += (thermistor_bias_switch_o.oe === 1'b0);
        cl_low += (cell_divider_switch_o.oe === 1'b0);
        bad_lvl += (cell_divider_switch_o.level !== 1'b0);
        bad_lvl += (thermistor_bias_switch_o.level !== 1'b0);
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] e,
                         input logic [63:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", what, e, g);
        end
    endtask : check

    task automatic sample(input logic signed [15:0] d);
        @(negedge clk_i);
        sense_input_high_i = 16'sh0100 + d;
        sense_input_low_i  = 16'sh0100;
        sense_valid_i      = 1'b1;
        @(negedge clk_i);
        sense_valid_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : sample

    task automatic cmd(input logic [15:0] v);
        @(negedge clk_i);
        vendor_cmd_wr_i           = 1'b1;
        vendor_command_register_i = v;
        @(negedge clk_i);
        vendor_cmd_wr_i = 1'b0;
    endtask : cmd

    task automatic t_charge();
        logic signed [15:0] d [7] = '{5, -5, 2, -2, 3, -3, 0};
        foreach (d[i])
        begin
            sample(d[i]);
            if (d[i] >= 3 || d[i] <= -3)
                exp_cc += 40'(d[i]) * 8;
            check("count", 64'(exp_cc), 64'(charge_count_o));
        end
        check("charge pulses", 2, n_chg);
        check("discharge pulses", 2, n_dis);
    endtask : t_charge

    task automatic t_cal();
        cmd(16'h0061);
        check("busy other", 0, cal_busy_o);
        cmd(16'h0062);
        check("busy", 1, cal_busy_o);
        sample(16'sd5);
        repeat (7) sample(16'sd0);
        check("busy end", 0, cal_busy_o);
        check("frozen", 64'(exp_cc), 64'(charge_count_o));
        // offset of five eighths of a count must come off exactly
        sample(16'sd5);
        exp_cc += 40'sd35;
        check("trim pos", 64'(exp_cc), 64'(charge_count_o));
        sample(-16'sd5);
        exp_cc -= 40'sd45;
        check("trim neg", 64'(exp_cc), 64'(charge_count_o));
    endtask : t_cal

    task automatic t_round(input logic [15:0] l, output int stamp);
        int n;
        lat    = l;
        th_low = 0;
        cl_low = 0;
        n      = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (round_done_o !== 1'b1 && n < 14000);
        stamp = cyc;
        check("round", 1, round_done_o);
        check("temperature", 16'h0a00, temperature_o);
        check("pack", 16'h0b11, pack_voltage_o);
        check("current", 16'h0c22, current_o);
        for (int g = 0; g < 4; g++)
            check("cell", 16'h0d33 + 16'(g) * 16'h0111,
                  cell_voltage_inputs_o[g]);
        check("therm win", 1, th_low inside {[240:252]});
        check("cell win", 1, cl_low inside {[1000:1012]});
    endtask : t_round

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {reset_n_i, sense_valid_i, vendor_cmd_wr_i} = 3'b000;
        {comp_edv_i, mwh_mode_i, max_rate_i, what_if_req_i} = 4'h0;
        sense_input_high_i        = 16'sh0000;
        sense_input_low_i         = 16'sh0000;
        vendor_command_register_i = 16'h0000;
        filter_threshold_i        = 16'h0003;
        lat    = 16'h0002;
        exp_cc = 40'sd0;
        repeat (10) @(negedge clk_i);
        check("rst data", 0, |{temperature_o, pack_voltage_o, current_o,
              cell_voltage_inputs_o, charge_count_o});
        check("rst sw", 4'h5,
              {cell_divider_switch_o, thermistor_bias_switch_o});
        reset_n_i = 1'b1;
        t_charge();
        t_cal();
        t_round(16'd100, s0);
        t_round(16'd2, s1);
        t_round(16'd2, s2);
        check("base gap", 1, (s2 - s1) inside {[7992:8008]});
        {comp_edv_i, mwh_mode_i, max_rate_i, what_if_req_i} = 4'hf;
        @(negedge clk_i);
        what_if_req_i = 1'b0;
        n_wif = 0;
        t_round(16'd2, s3);
        check("what-if", 1, n_wif);
        t_round(16'd2, s4);
        check("long gap", 1, (s4 - s3) inside {[11992:12008]});
        n_wif = 0;
        repeat (4) t_round(16'd2, s0);
        check("timed what-if", 1, n_wif);
        check("sw level", 0, bad_lvl);
        close_out();
    end

    initial
    begin
        repeat (92000) @(posedge clk_i);
        err_total++;
        close_out();
    end
endmodule : tb
